// ===== ccd_pkg.sv
// Shared constants and carrier types for the clock source divider and timewheel block
`default_nettype none
package ccd_pkg;
  localparam int unsigned CLK_HZ = 100_000_000;
  localparam int unsigned NUM_DIV = 12;
  // Register offsets
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_FAST_TC = 8'h01;
  localparam logic [7:0] ADDR_CTC_TAP = 8'h02;
  localparam logic [7:0] ADDR_STATUS = 8'h03;
  localparam logic [7:0] ADDR_CTC_VAL = 8'h04;
  localparam logic [7:0] ADDR_BUS_DIV = 8'h05;
  localparam logic [7:0] ADDR_CPU_DIV = 8'h06;
  localparam logic [7:0] ADDR_MASTER_SEL = 8'h07;
  localparam logic [7:0] ADDR_PLL_DIV = 8'h08;
  localparam logic [7:0] ADDR_SRC_EN = 8'h09;
  localparam logic [7:0] ADDR_DIV_VAL = 8'h10;
  localparam logic [7:0] ADDR_DIV_SRC = 8'h20;
  // Control register field positions
  localparam int unsigned CTRL_CLEAR = 0;
  localparam int unsigned CTRL_FAST_IRQ = 1;
  localparam int unsigned CTRL_CTC_IRQ = 2;
  localparam int unsigned CTRL_WAKE = 3;
  localparam int unsigned CTRL_PLL_EN = 4;
  localparam int unsigned CTRL_IMO_FREQ = 5;
  localparam int unsigned CTRL_DBL_SEL = 7;
  localparam int unsigned CTRL_PLL_REF = 9;
  // Source indices on the divider input multiplexers
  localparam logic [2:0] SRC_PLL = 3'h3;
  localparam logic [2:0] SRC_LSO = 3'h5;
  localparam logic [2:0] SRC_WATCH = 3'h6;
  localparam logic [2:0] SRC_TAP33 = 3'h7;
  // Reset values and the central counter tap limit
  localparam logic [15:0] RST_DIV = 16'h0002;
  localparam logic [3:0] RST_CPU_DIV = 4'h2;
  localparam logic [4:0] RST_FAST_TC = 5'h1f;
  localparam logic [3:0] RST_CTC_TAP = 4'h9;
  localparam logic [6:0] RST_SRC_EN = 7'h01;
  localparam logic [5:0] RST_PLL_DIV = 6'h01;
  localparam logic [3:0] CTC_TAP_MAX = 4'hc;
  // Low-speed oscillator tap ratios and the watch crystal second count
  localparam logic [1:0] DIV3_LAST = 2'h2;
  localparam logic [6:0] DIV100_LAST = 7'h63;
  localparam logic [14:0] SEC_LAST = 15'h7fff;
  // Startup and lock times
  localparam int unsigned IMO_START_US = 13;
  localparam int unsigned DBL_START_US = 1;
  localparam int unsigned PLL_LOCK_US = 250;
  localparam int unsigned XTAL_START_MS = 5;
  localparam int unsigned LSO_START_MS = 15;
  localparam int unsigned WATCH_START_MS = 500;
  localparam int unsigned IMO_START_CYC = IMO_START_US * (CLK_HZ / 1_000_000);
  localparam int unsigned DBL_START_CYC = DBL_START_US * (CLK_HZ / 1_000_000);
  localparam int unsigned PLL_LOCK_CYC = PLL_LOCK_US * (CLK_HZ / 1_000_000);
  localparam int unsigned XTAL_START_CYC = XTAL_START_MS * (CLK_HZ / 1_000);
  localparam int unsigned LSO_START_CYC = LSO_START_MS * (CLK_HZ / 1_000);
  localparam int unsigned WATCH_START_CYC = WATCH_START_MS * (CLK_HZ / 1_000);

  // Sampled source levels; imo is bit 0 when viewed as a vector
  typedef struct packed {
    logic watch_crystal_osc;
    logic slow_tap_100k;
    logic doubler;
    logic pll;
    logic dsi;
    logic fast_crystal_osc;
    logic internal_main_osc;
  } ccd_src_type;

  // Controls driven to the analog oscillators, PLL and doubler
  typedef struct packed {
    logic       pll_en;
    logic [1:0] imo_freq;
    logic [1:0] doubler_sel;
    logic [1:0] pll_ref_sel;
    logic [5:0] pll_in_div;
    logic [5:0] pll_fb_div;
    logic [6:0] src_en;
  } ccd_ctl_type;
endpackage
`default_nettype wire

// ===== ccd_clock_ctrl.sv
// Clock source control, dividers and timewheels in the master clock domain
`default_nettype none
// Operation
// - Central tick counter is a free-running 13-bit counter on the 1 kHz tap.
// - Central counter stops in hibernate and while debug halts the CPU.
// - Central counter raises periodic interrupts and wake requests.
// - Firmware clear returns the central counter to zero; it then keeps counting.
// - Fast tick counter is 5-bit on the 100 kHz tap with programmable terminal.
// - Fast counter restarts from zero at its terminal count by itself.
// - Fast counter raises an interrupt at each terminal count when enabled.
// - The 33 kHz tap is the 100 kHz tap divided by three.
// - Low-speed oscillator offers 1 kHz, 33 kHz and 100 kHz taps.
// - Doubler doubles its input, 24 MHz into 48 MHz for USB.
// - Doubler input selects main oscillator, fast crystal or interconnect.
// - PLL reference selects main oscillator, fast crystal or interconnect.
// - PLL gives 24 to 50 MHz with 4032 divider ratios.
// - PLL locks within 250 us of enable and sets a readable lock bit.
// - Lock indication can be routed to the interconnect for an interrupt.
// - Main oscillator frequency selects 3, 6, 12 or 24 MHz.
// - Eight digital and four analog 16-bit dividers.
// - Bus clock from a 16-bit divider, CPU clock from a 4-bit divider.
// - Every peripheral divider has its own independent source select.
// - Watch crystal path gives a once-per-second interrupt.
// - CPU divider runs from bus clock; bus divider from master clock.
// - Peripheral and bus dividers use an 8-input mux, divide by two or more, resynchronised.
module ccd_clock_ctrl #(
  parameter int unsigned PLL_LOCK_CYC    = ccd_pkg::PLL_LOCK_CYC,
  parameter int unsigned XTAL_START_CYC  = ccd_pkg::XTAL_START_CYC,
  parameter int unsigned LSO_START_CYC   = ccd_pkg::LSO_START_CYC,
  parameter int unsigned WATCH_START_CYC = ccd_pkg::WATCH_START_CYC
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic [7:0]          addr_i,
  input  wire logic [15:0]         wdata_i,
  input  wire logic                wr_i,
  input  wire logic                rd_i,
  output logic      [15:0]         rdata_o,
  input  wire ccd_pkg::ccd_src_type src_i,
  input  wire logic                hibernate_i,
  input  wire logic                debug_halt_i,
  output ccd_pkg::ccd_ctl_type     ctl_o,
  output logic      [2:0]          master_sel_o,
  output logic      [6:0]          ready_o,
  output logic                     lock_o,
  output logic                     tap_33k_o,
  output logic                     tap_1k_o,
  output logic                     ctc_irq_o,
  output logic                     wake_o,
  output logic                     fast_irq_o,
  output logic                     second_irq_o,
  output logic                     bus_clk_o,
  output logic                     cpu_clk_o,
  output logic      [11:0]         div_clk_o
);
  import ccd_pkg::*;
  typedef struct packed {
    logic [6:0]        src_prev;
    logic [1:0]        div3;
    logic [6:0]        div100;
    logic              tap33;
    logic              tap1k;
    logic [12:0]       ctc;
    logic [3:0]        ctc_tap;
    logic [4:0]        fast;
    logic [4:0]        fast_tc;
    logic              fast_irq_en;
    logic              ctc_irq_en;
    logic              wake_en;
    logic [14:0]       sec;
    ccd_ctl_type       ctl;
    logic [2:0]        master_req;
    logic [2:0]        master_act;
    logic [6:0][25:0]  start_cnt;
    logic [6:0]        ready;
    logic [11:0][15:0] dv_val;
    logic [11:0][2:0]  dv_sel;
    logic [11:0][15:0] dv_aval;
    logic [11:0][2:0]  dv_asel;
    logic [11:0][15:0] dv_cnt;
    logic [11:0]       dv_out;
    logic [15:0]       bus_val;
    logic [15:0]       bus_aval;
    logic [15:0]       bus_cnt;
    logic              bus_out;
    logic [3:0]        cpu_val;
    logic [3:0]        cpu_aval;
    logic [3:0]        cpu_cnt;
    logic              cpu_out;
    logic              ctc_irq;
    logic              wake;
    logic              fast_irq;
    logic              sec_irq;
    logic [15:0]       rdata;
  } ccd_state_type;
  ccd_state_type s_reg;
  ccd_state_type s_next;
  logic [7:0]    edge_v;
  logic          tick100;
  logic          tick33;
  logic          tick1k;
  logic          ctc_run;
  logic          ctc_clear;
  logic          bus_rise;
  // Divide values below two act as two so every phase spans at least one source edge
  function automatic logic [15:0] eff_div(input logic [15:0] dv);
    eff_div = (dv < 16'h0002) ? 16'h0002 : dv;
  endfunction
  function automatic logic [15:0] div_step(input logic [15:0] cnt, input logic [15:0] dv);
    div_step = (cnt >= eff_div(dv) - 16'h0001) ? 16'h0000 : cnt + 16'h0001;
  endfunction
  function automatic logic div_phase(input logic [15:0] cnt, input logic [15:0] dv);
    div_phase = (cnt < (eff_div(dv) >> 1));
  endfunction
  // The 33 kHz tap counts as ready once the low-speed oscillator is
  function automatic logic src_ready(input logic [6:0] rdy, input logic [2:0] idx);
    src_ready = (idx == SRC_TAP33) ? rdy[SRC_LSO] : rdy[idx];
  endfunction
  function automatic logic [25:0] start_lim(input int i);
    case (i)
      0:       start_lim = 26'(IMO_START_CYC);
      1:       start_lim = 26'(XTAL_START_CYC);
      3:       start_lim = 26'(PLL_LOCK_CYC);
      4:       start_lim = 26'(DBL_START_CYC);
      5:       start_lim = 26'(LSO_START_CYC);
      6:       start_lim = 26'(WATCH_START_CYC);
      default: start_lim = 26'h0000001;
    endcase
  endfunction
  function automatic logic [15:0] reg_read(input ccd_state_type s, input logic [7:0] a);
    reg_read = 16'h0000;
    if (a >= ADDR_DIV_VAL && a < ADDR_DIV_VAL + 8'(NUM_DIV)) begin
      reg_read = s.dv_val[4'(a - ADDR_DIV_VAL)];
    end else if (a >= ADDR_DIV_SRC && a < ADDR_DIV_SRC + 8'(NUM_DIV)) begin
      reg_read = {13'h0000, s.dv_sel[4'(a - ADDR_DIV_SRC)]};
    end else begin
      case (a)
        ADDR_CTRL: reg_read = {5'h00, s.ctl.pll_ref_sel, s.ctl.doubler_sel, s.ctl.imo_freq,
                               s.ctl.pll_en, s.wake_en, s.ctc_irq_en, s.fast_irq_en, 1'b0};
        ADDR_FAST_TC:    reg_read = {11'h000, s.fast_tc};
        ADDR_CTC_TAP:    reg_read = {12'h000, s.ctc_tap};
        ADDR_STATUS:     reg_read = {5'h00, s.master_act, 1'b0, s.ready};
        ADDR_CTC_VAL:    reg_read = {3'h0, s.ctc};
        ADDR_BUS_DIV:    reg_read = s.bus_val;
        ADDR_CPU_DIV:    reg_read = {12'h000, s.cpu_val};
        ADDR_MASTER_SEL: reg_read = {13'h0000, s.master_req};
        ADDR_PLL_DIV:    reg_read = {4'h0, s.ctl.pll_fb_div, s.ctl.pll_in_div};
        ADDR_SRC_EN:     reg_read = {9'h000, s.ctl.src_en};
        default:         reg_read = 16'h0000;
      endcase
    end
  endfunction
  always_comb begin
    s_next = s_reg;
    s_next.ctc_irq = 1'b0;
    s_next.wake = 1'b0;
    s_next.fast_irq = 1'b0;
    s_next.sec_irq = 1'b0;
    tick33 = 1'b0;
    tick1k = 1'b0;
    s_next.src_prev = 7'(src_i);
    edge_v[6:0] = 7'(src_i) & ~s_reg.src_prev;
    tick100 = edge_v[SRC_LSO];
    // Low-speed taps: 100 kHz edge, /3 and /100 strobes
    if (tick100) begin
      tick33 = (s_reg.div3 == DIV3_LAST);
      s_next.div3 = tick33 ? 2'h0 : s_reg.div3 + 2'h1;
      tick1k = (s_reg.div100 == DIV100_LAST);
      s_next.div100 = tick1k ? 7'h00 : s_reg.div100 + 7'h01;
    end
    edge_v[SRC_TAP33] = tick33;
    s_next.tap33 = tick33;
    s_next.tap1k = tick1k;
    // Central tick counter
    ctc_clear = wr_i && addr_i == ADDR_CTRL && wdata_i[CTRL_CLEAR];
    ctc_run = tick1k && !hibernate_i && !debug_halt_i;
    if (ctc_clear) begin
      s_next.ctc = 13'h0000;
    end else if (ctc_run) begin
      s_next.ctc = s_reg.ctc + 13'h0001;
      if (s_reg.ctc[s_reg.ctc_tap] && !s_next.ctc[s_reg.ctc_tap]) begin
        s_next.ctc_irq = s_reg.ctc_irq_en;
        s_next.wake = s_reg.wake_en;
      end
    end
    // Fast tick counter; oscillator is off in hibernate
    if (tick100 && !hibernate_i) begin
      if (s_reg.fast >= s_reg.fast_tc) begin
        s_next.fast = 5'h00;
        s_next.fast_irq = s_reg.fast_irq_en;
      end else begin
        s_next.fast = s_reg.fast + 5'h01;
      end
    end
    // Once-per-second strobe from 32768 watch crystal edges
    if (edge_v[SRC_WATCH]) begin
      s_next.sec = s_reg.sec + 15'h0001;
      s_next.sec_irq = (s_reg.sec == SEC_LAST);
    end
    // Startup timers; the PLL entry is the lock timer and clears on disable
    for (int i = 0; i < 7; i++) begin
      if (!((i == 3) ? s_reg.ctl.pll_en : s_reg.ctl.src_en[i])) begin
        s_next.start_cnt[i] = 26'h0000000;
        s_next.ready[i] = 1'b0;
      end else if (s_reg.start_cnt[i] >= start_lim(i) - 26'h0000001) begin
        s_next.ready[i] = 1'b1;
      end else begin
        s_next.start_cnt[i] = s_reg.start_cnt[i] + 26'h0000001;
      end
    end
    // A master request waits until its source reports ready
    if (src_ready(s_reg.ready, s_reg.master_req)) begin
      s_next.master_act = s_reg.master_req;
    end
    // Peripheral dividers; new settings load only at the end of a full period
    for (int i = 0; i < NUM_DIV; i++) begin
      if (edge_v[s_reg.dv_asel[i]]) begin
        s_next.dv_cnt[i] = div_step(s_reg.dv_cnt[i], s_reg.dv_aval[i]);
        if (s_next.dv_cnt[i] == 16'h0000) begin
          s_next.dv_aval[i] = s_reg.dv_val[i];
          if (src_ready(s_reg.ready, s_reg.dv_sel[i])) begin
            s_next.dv_asel[i] = s_reg.dv_sel[i];
          end
        end
      end
      s_next.dv_out[i] = div_phase(s_next.dv_cnt[i], s_next.dv_aval[i]);
    end
    // Bus divider on master edges, CPU divider on bus clock rises
    if (edge_v[s_reg.master_act]) begin
      s_next.bus_cnt = div_step(s_reg.bus_cnt, s_reg.bus_aval);
      if (s_next.bus_cnt == 16'h0000) begin
        s_next.bus_aval = s_reg.bus_val;
      end
    end
    s_next.bus_out = div_phase(s_next.bus_cnt, s_next.bus_aval);
    bus_rise = s_next.bus_out && !s_reg.bus_out;
    if (bus_rise) begin
      s_next.cpu_cnt = 4'(div_step({12'h000, s_reg.cpu_cnt}, {12'h000, s_reg.cpu_aval}));
      if (s_next.cpu_cnt == 4'h0) begin
        s_next.cpu_aval = s_reg.cpu_val;
      end
    end
    s_next.cpu_out = div_phase({12'h000, s_next.cpu_cnt}, {12'h000, s_next.cpu_aval});
    // Register writes
    if (wr_i) begin
      if (addr_i >= ADDR_DIV_VAL && addr_i < ADDR_DIV_VAL + 8'(NUM_DIV)) begin
        s_next.dv_val[4'(addr_i - ADDR_DIV_VAL)] = wdata_i;
      end else if (addr_i >= ADDR_DIV_SRC && addr_i < ADDR_DIV_SRC + 8'(NUM_DIV)) begin
        s_next.dv_sel[4'(addr_i - ADDR_DIV_SRC)] = wdata_i[2:0];
      end else begin
        case (addr_i)
          ADDR_CTRL: begin
            s_next.fast_irq_en = wdata_i[CTRL_FAST_IRQ];
            s_next.ctc_irq_en = wdata_i[CTRL_CTC_IRQ];
            s_next.wake_en = wdata_i[CTRL_WAKE];
            s_next.ctl.pll_en = wdata_i[CTRL_PLL_EN];
            s_next.ctl.imo_freq = wdata_i[CTRL_IMO_FREQ +: 2];
            s_next.ctl.doubler_sel = wdata_i[CTRL_DBL_SEL +: 2];
            s_next.ctl.pll_ref_sel = wdata_i[CTRL_PLL_REF +: 2];
          end
          ADDR_FAST_TC: s_next.fast_tc = wdata_i[4:0];
          ADDR_CTC_TAP: s_next.ctc_tap = (wdata_i[3:0] > CTC_TAP_MAX) ? CTC_TAP_MAX : wdata_i[3:0];
          ADDR_BUS_DIV: s_next.bus_val = wdata_i;
          ADDR_CPU_DIV: s_next.cpu_val = wdata_i[3:0];
          ADDR_MASTER_SEL: s_next.master_req = wdata_i[2:0];
          ADDR_PLL_DIV: begin
            s_next.ctl.pll_in_div = wdata_i[5:0];
            s_next.ctl.pll_fb_div = wdata_i[11:6];
          end
          ADDR_SRC_EN: s_next.ctl.src_en = wdata_i[6:0];
          default: ;
        endcase
      end
    end
    s_next.rdata = rd_i ? reg_read(s_reg, addr_i) : 16'h0000;
  end

  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_reg <= '0;
      s_reg.fast_tc <= RST_FAST_TC;
      s_reg.ctc_tap <= RST_CTC_TAP;
      s_reg.ctl.src_en <= RST_SRC_EN;
      s_reg.ctl.pll_in_div <= RST_PLL_DIV;
      s_reg.ctl.pll_fb_div <= RST_PLL_DIV;
      s_reg.dv_val <= {NUM_DIV{RST_DIV}};
      s_reg.dv_aval <= {NUM_DIV{RST_DIV}};
      s_reg.bus_val <= RST_DIV;
      s_reg.bus_aval <= RST_DIV;
      s_reg.cpu_val <= RST_CPU_DIV;
      s_reg.cpu_aval <= RST_CPU_DIV;
    end else begin
      s_reg <= s_next;
    end
  end

  assign rdata_o = s_reg.rdata;
  assign ctl_o = s_reg.ctl;
  assign master_sel_o = s_reg.master_act;
  assign ready_o = s_reg.ready;
  assign lock_o = s_reg.ready[SRC_PLL];
  assign tap_33k_o = s_reg.tap33;
  assign tap_1k_o = s_reg.tap1k;
  assign ctc_irq_o = s_reg.ctc_irq;
  assign wake_o = s_reg.wake;
  assign fast_irq_o = s_reg.fast_irq;
  assign second_irq_o = s_reg.sec_irq;
  assign bus_clk_o = s_reg.bus_out;
  assign cpu_clk_o = s_reg.cpu_out;
  assign div_clk_o = s_reg.dv_out;
  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  property p_ctc_count;
    ctc_run && !ctc_clear |=> s_reg.ctc == $past(s_reg.ctc) + 13'h0001;
  endproperty
  a_ctc_count: assert property (p_ctc_count) else $error("central counter missed a tick");
  property p_ctc_halt;
    (hibernate_i || debug_halt_i) && !ctc_clear |=> $stable(s_reg.ctc);
  endproperty
  a_ctc_halt: assert property (p_ctc_halt) else $error("central counter moved while halted");
  property p_ctc_clear;
    ctc_clear |=> s_reg.ctc == 13'h0000;
  endproperty
  a_ctc_clear: assert property (p_ctc_clear) else $error("central counter not cleared");
  property p_fast_wrap;
    tick100 && !hibernate_i && s_reg.fast >= s_reg.fast_tc |=> s_reg.fast == 5'h00;
  endproperty
  a_fast_wrap: assert property (p_fast_wrap) else $error("fast counter did not restart");
  property p_fast_irq;
    fast_irq_o |-> $past(s_reg.fast) >= $past(s_reg.fast_tc) && s_reg.fast == 5'h00;
  endproperty
  a_fast_irq: assert property (p_fast_irq) else $error("fast interrupt without terminal");
  property p_tap33;
    tick33 |-> tick100 ##1 !tick33 ##1 !tick33;
  endproperty
  a_tap33: assert property (p_tap33) else $error("33 kHz tap not a divide by three");
  property p_lock_drop;
    !ctl_o.pll_en |=> !lock_o;
  endproperty
  a_lock_drop: assert property (p_lock_drop) else $error("lock held with PLL off");
  property p_master_ready;
    master_sel_o != $past(master_sel_o) |-> src_ready(ready_o, master_sel_o);
  endproperty
  a_master_ready: assert property (p_master_ready) else $error("switched to unready source");
  property p_div_quiet;
    // The first edge after reset raises the count-zero phase with no source edge behind it
    !edge_v[s_reg.dv_asel[0]] && !$past(rst_i) |=> div_clk_o[0] == $past(div_clk_o[0]);
  endproperty
  a_div_quiet: assert property (p_div_quiet) else $error("divider moved without edge");
  property p_cpu_on_bus;
    !bus_clk_o || $past(bus_clk_o) |-> cpu_clk_o == $past(cpu_clk_o);
  endproperty
  a_cpu_on_bus: assert property (p_cpu_on_bus) else $error("CPU clock moved off bus rise");
  c_fast_irq: cover property (fast_irq_o);
  c_lock: cover property (!lock_o ##1 lock_o);
  c_wake: cover property (wake_o);
  c_second: cover property (second_irq_o);
endmodule
`default_nettype wire

// ===== ccd_src_model.sv
// Behavioural model of the oscillators, PLL and doubler feeding the block
`default_nettype none
module ccd_src_model (
  input  wire logic                 clk_i,
  input  wire logic                 rst_i,
  input  wire ccd_pkg::ccd_ctl_type ctl_i,
  output ccd_pkg::ccd_src_type      src_o
);
  timeunit 1ns;
  timeprecision 1ps;
  import ccd_pkg::*;
  logic [7:0] tick_reg;
  logic [6:0] en;
  // A source that is switched off stands still low instead of running free
  assign en = ctl_i.src_en & {3'h7, ctl_i.pll_en, 3'h7};
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      tick_reg <= 8'h00;
    end else begin
      tick_reg <= tick_reg + 8'h01;
    end
  end
  // Slow taps run at a quarter and an eighth of the master rate to keep runs short
  assign src_o = en & {tick_reg[2], tick_reg[1], {5{tick_reg[0]}}};
endmodule
`default_nettype wire

// ===== ccd_clock_ctrl_tb_top.sv
// Self-checking testbench for the clock control block
`default_nettype none
module ccd_clock_ctrl_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import ccd_pkg::*;
  localparam int LOCK = 20;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic [7:0]  addr_i = 8'h00;
  logic [15:0] wdata_i = 16'h0000;
  logic        wr_i = 1'b0;
  logic        rd_i = 1'b0;
  logic        hibernate_i = 1'b0;
  logic        debug_halt_i = 1'b0;
  logic [15:0] rdata_o;
  ccd_src_type src_i;
  ccd_ctl_type ctl_o;
  logic [2:0]  master_sel_o;
  logic [6:0]  ready_o;
  logic        lock_o, tap_33k_o, tap_1k_o, ctc_irq_o, wake_o, fast_irq_o, second_irq_o;
  logic        bus_clk_o, cpu_clk_o;
  logic [11:0] div_clk_o;
  logic [15:0] exp_q[$];
  logic        rd_d = 1'b0;
  int          err_count = 0;
  int          n_compared = 0;
  int          n, v, w;

  always #5 clk_i = ~clk_i;
  ccd_src_model ccd_src_model_i (.clk_i, .rst_i, .ctl_i(ctl_o), .src_o(src_i));
  ccd_clock_ctrl #(.PLL_LOCK_CYC(LOCK), .XTAL_START_CYC(30), .LSO_START_CYC(30),
    .WATCH_START_CYC(30)) ccd_clock_ctrl_i (.clk_i, .rst_i, .addr_i, .wdata_i, .wr_i, .rd_i,
    .rdata_o, .src_i, .hibernate_i, .debug_halt_i, .ctl_o, .master_sel_o, .ready_o, .lock_o,
    .tap_33k_o, .tap_1k_o, .ctc_irq_o, .wake_o, .fast_irq_o, .second_irq_o, .bus_clk_o,
    .cpu_clk_o, .div_clk_o);

  task automatic chk(input string what, input logic [15:0] e, input logic [15:0] got);
    n_compared++;
    if (got !== e) begin
      err_count++;
      $display("Error %s expected %h seen %h", what, e, got);
    end
  endtask

  task automatic tally_and_finish();
    $display("Compared %0d, mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge clk_i);
    wr_i <= 1'b0;
  endtask

  // Noted reads are judged by the monitor; unnoted ones hand the value back
  task automatic rd(input logic [7:0] a, input logic [15:0] e, input bit note, output int got);
    @(posedge clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    if (note) exp_q.push_back(e);
    @(posedge clk_i);
    rd_i <= 1'b0;
    @(posedge clk_i);
    got = rdata_o;
  endtask

  always @(posedge clk_i) begin
    rd_d <= rd_i;
    if (rd_d && exp_q.size() > 0) chk("rdata", exp_q.pop_front(), rdata_o);
  end

  // Counts rises of watched bit u between two rises of the watched output s
  task automatic span(input int s, output int cnt, input int u = 0);
    logic [9:0] p, c;
    int t;
    bit f;
    t = 0;
    p = '1;
    repeat (2) begin
      cnt = 0;
      do begin
        @(negedge clk_i);
        c = {src_i.pll, cpu_clk_o, bus_clk_o, div_clk_o[0], wake_o, ctc_irq_o, tap_1k_o,
             tap_33k_o, fast_irq_o, src_i.slow_tap_100k};
        if (c[u] && !p[u]) cnt++;
        f = c[s] && !p[s];
        p = c;
        t++;
      end while (!f && t < 8000);
    end
    // A pulse that never comes must not pass as a count
    if (!f) cnt = -1;
  endtask

  initial begin
    #600_000;
    err_count++;
    $display("Error watchdog expected end of tests seen timeout");
    tally_and_finish();
  end

  initial begin
    void'($urandom(32'h829d));
    repeat (2) @(posedge clk_i);
    rst_i <= 1'b0;
    rd(ADDR_FAST_TC, 16'h001f, 1, v);
    rd(ADDR_BUS_DIV, 16'h0002, 1, v);
    rd(ADDR_CPU_DIV, 16'h0002, 1, v);
    rd(8'h3f, 16'h0000, 1, v);
    wr(ADDR_CTC_TAP, 16'h000f);
    rd(ADDR_CTC_TAP, 16'h000c, 1, v);
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_CTRL, 16'(i << CTRL_IMO_FREQ | (i % 3) << CTRL_DBL_SEL | (i % 3) << CTRL_PLL_REF));
      @(negedge clk_i);
      chk("imo_freq", 16'(i), 16'(ctl_o.imo_freq));
      chk("doubler_sel", 16'(i % 3), 16'(ctl_o.doubler_sel));
      chk("pll_ref_sel", 16'(i % 3), 16'(ctl_o.pll_ref_sel));
    end
    w = $urandom;
    wr(ADDR_PLL_DIV, 16'(w[11:0]));
    @(negedge clk_i);
    chk("pll dividers", 16'(w[11:0]), 16'({ctl_o.pll_fb_div, ctl_o.pll_in_div}));
    wr(ADDR_SRC_EN, 16'h007f);
    wr(ADDR_MASTER_SEL, 16'(SRC_PLL));
    @(negedge clk_i);
    chk("master before lock", 16'h0000, 16'(master_sel_o));
    wr(ADDR_CTRL, 16'h0001 << CTRL_PLL_EN);
    n = 0;
    while (lock_o !== 1'b1 && n < 100) begin
      @(negedge clk_i);
      n++;
    end
    chk("lock in time", 16'h0001, 16'(n >= LOCK - 1 && n <= LOCK + 3));
    rd(ADDR_STATUS, 16'h0000, 0, v);
    chk("status lock", 16'h0001, 16'(v[3]));
    wr(ADDR_MASTER_SEL, 16'(SRC_PLL));
    @(negedge clk_i);
    chk("master after lock", 16'(SRC_PLL), 16'(master_sel_o));
    w = 2 + int'($urandom % 20);
    wr(ADDR_FAST_TC, 16'(w));
    wr(ADDR_CTC_TAP, 16'h0000);
    wr(ADDR_CTRL, 16'h001e);
    span(1, n);
    chk("fast period", 16'(w + 1), 16'(n));
    span(2, n);
    chk("33k period", 16'd3, 16'(n));
    span(3, n);
    chk("1k period", 16'd100, 16'(n));
    span(4, n);
    chk("central irq period", 16'd200, 16'(n));
    span(5, n);
    chk("wake period", 16'd200, 16'(n));
    wr(ADDR_DIV_SRC, 16'(SRC_LSO));
    for (int k = 1; k < 8; k += 4) begin
      wr(ADDR_DIV_VAL, 16'(k));
      span(6, n);
      chk("divider period", 16'(k < 2 ? 2 : k), 16'(n));
    end
    span(7, n, 9);
    chk("bus period", RST_DIV, 16'(n));
    span(8, n, 7);
    chk("cpu period", 16'(RST_CPU_DIV), 16'(n));
    wr(ADDR_CTRL, 16'h0000);
    for (int m = 0; m < 2; m++) begin
      hibernate_i <= (m == 0);
      debug_halt_i <= (m == 1);
      rd(ADDR_CTC_VAL, 16'h0000, 0, v);
      repeat (1000) @(posedge clk_i);
      rd(ADDR_CTC_VAL, 16'h0000, 0, w);
      chk("frozen count", 16'(v), 16'(w));
    end
    debug_halt_i <= 1'b0;
    repeat (1000) @(posedge clk_i);
    rd(ADDR_CTC_VAL, 16'h0000, 0, v);
    chk("counts again", 16'h0001, 16'(v > w));
    wr(ADDR_CTRL, 16'h0001 << CTRL_CLEAR);
    rd(ADDR_CTC_VAL, 16'h0000, 0, v);
    chk("cleared", 16'h0001, 16'(v <= 1));
    repeat (1000) @(posedge clk_i);
    rd(ADDR_CTC_VAL, 16'h0000, 0, v);
    chk("resumes", 16'h0001, 16'(v >= 2 && v <= 4));
    tally_and_finish();
  end
endmodule
`default_nettype wire
